// file: gpc_consts.vh
`ifndef GPC_CONSTS_VH
`define GPC_CONSTS_VH

// Register bus
`define GPC_REG_INDEX       12'hFD0
`define GPC_REG_WINDOW      12'hFD1
`define GPC_REG_IN_DATA     12'hFD2
`define GPC_REG_OUT_DATA    12'hFD3
`define GPC_PORT_SHIFT      2
`define GPC_PORT_BASE       12'hFD0
`define GPC_PORT_SPAN       12'h010

// Register select within a port's four addresses
`define GPC_SEL_INDEX       2'h0
`define GPC_SEL_WINDOW      2'h1
`define GPC_SEL_IN_DATA     2'h2
`define GPC_SEL_OUT_DATA    2'h3

// Sub-register index values
`define GPC_SUB_NONE        8'h00
`define GPC_SUB_DIR         8'h01
`define GPC_SUB_ALT_EN      8'h02
`define GPC_SUB_OPEN_DRAIN  8'h03
`define GPC_SUB_HIGH_DRIVE  8'h04
`define GPC_SUB_WAKE_SRC    8'h05
`define GPC_SUB_PULLUP      8'h06
`define GPC_SUB_ALT_SEL1    8'h07
`define GPC_SUB_ALT_SEL2    8'h08

// Reset values
`define GPC_RST_ZERO        8'h00
`define GPC_RST_DIR         8'hFF
`define GPC_RST_ALT_ABC     8'h00
`define GPC_RST_ALT_D       8'h01
`define GPC_RST_ALT_A8      8'h04
`define GPC_RST_SEL_A8      8'h04

`define GPC_NPORTS          4
`define GPC_PORT_D          2'h3

`endif

// file: gpc_pin_cell.v
`timescale 1ns/100ps
`default_nettype none

// Drive decision for one pin
module gpc_pin_cell (
    // Configuration
    input  wire       direction_bit,
    input  wire       alt_enable_bit,
    input  wire       open_drain_bit,
    input  wire       high_drive_bit,
    input  wire       pullup_bit,
    input  wire       out_data,
    // Alternate function side
    input  wire       alt_out,
    input  wire       alt_oe,
    // Pin side
    output wire       pin_out,
    output wire       pin_oe,
    output wire       pin_high_drive,
    output wire       pin_pullup
);
    wire drive_val;
    wire drive_en;

    assign drive_val = alt_enable_bit ? alt_out : out_data;
    assign drive_en  = alt_enable_bit ? alt_oe : ~direction_bit;
    // Low side always allowed, high side blocked in open-drain mode
    assign pin_oe    = drive_en & ~(open_drain_bit & drive_val);
    assign pin_out   = drive_val;
    assign pin_high_drive = high_drive_bit;
    assign pin_pullup = pullup_bit;
endmodule

`default_nettype wire

// file: gpc_pin_model.sv
`timescale 1ns/100ps
`default_nettype none

// Pads plus an outside driver facing the port pins
module gpc_pin_model (
    input  wire logic        mclk,
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe,
    input  wire logic [31:0] pin_pullup,
    input  wire logic [31:0] ext_val,
    input  wire logic [31:0] ext_oe,
    output logic [31:0]      pin_in
);
    logic [31:0] drift = 32'h0;

    // Floating pins wander, so a stale level never passes for a driven one
    always @(posedge mclk) begin
        drift <= ~drift;
    end

    always_comb begin
        pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
               | (~pin_oe & ~ext_oe & (pin_pullup | drift));
    end
endmodule

`default_nettype wire

// file: gpc_port_cfg.v
// Behaviour
// - Window access goes to the sub-register named by the port index.
// - Direction 0 drives output data; 1 tristates and samples pin.
// - Index 02H maps alternate-function enable into the window.
// - Alternate enable 0: plain I/O, direction from direction bit.
// - Alternate enable 1: pin controlled by selected alternate function.
// - Two select bits pick one of four alternate functions.
// - Alternate enable resets 00H ports A-C, 01H D, 04H 8-pin A.
// - Index 03H maps open-drain select into the window.
// - Open-drain bit 1 disables high-side sourcing, even in alternate mode.
// - Open-drain bit 0 allows push-pull unless alternate overrides.
// - Open-drain and high-drive act at the pin, alternate too.
// - Index 04H maps high-current select into the window.
// - High-drive bit 1 selects high current, 0 standard.
// - Index 05H maps wake-source enable into the window.
// - In deep sleep, any edge on enabled wake pin starts recovery.
// - In deep sleep, edges on non-enabled pins are ignored.
// - Index 06H maps weak pull-up enable into the window.
// - Pull-up bit 1 connects weak pull-up, 0 disconnects.
`timescale 1ns/100ps
`default_nettype none
`include "gpc_consts.vh"

module gpc_port_cfg #(
    parameter EIGHT_PIN = 0
) (
    // Clock and reset
    input  wire        mclk,
    input  wire        rstn,
    // Register port
    input  wire [11:0] reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output wire        reg_hit,
    // Power state
    input  wire        deep_sleep,
    output wire        wake_req,
    // Alternate function side, per port 8 pins, 4 functions each
    input  wire [31:0] alt_out_a,
    input  wire [31:0] alt_oe_a,
    input  wire [31:0] alt_out_b,
    input  wire [31:0] alt_oe_b,
    input  wire [31:0] alt_out_c,
    input  wire [31:0] alt_oe_c,
    input  wire [31:0] alt_out_d,
    input  wire [31:0] alt_oe_d,
    // Pins, ports A..D packed low to high
    input  wire [31:0] pin_in,
    output wire [31:0] pin_out,
    output wire [31:0] pin_oe,
    output wire [31:0] pin_high_drive,
    output wire [31:0] pin_pullup,
    output wire [31:0] pin_alt_in,
    output wire [31:0] pin_alt_sel
);
    reg        rst_s1;
    reg        rst_n;
    reg [7:0]  sub_index [0:3];
    reg [7:0]  dir_reg   [0:3];
    reg [7:0]  alt_en    [0:3];
    reg [7:0]  od_reg    [0:3];
    reg [7:0]  hd_reg    [0:3];
    reg [7:0]  wake_reg  [0:3];
    reg [7:0]  pu_reg    [0:3];
    reg [7:0]  sel1_reg  [0:3];
    reg [7:0]  sel2_reg  [0:3];
    reg [7:0]  out_reg   [0:3];
    reg [7:0]  in_reg    [0:3];
    reg [7:0]  next_rdata;
    wire [1:0] port_sel;
    wire [1:0] reg_sel;
    wire [3:0] port_wake;
    wire [7:0] win_rdata;
    wire [127:0] alt_out_all;
    wire [127:0] alt_oe_all;
    integer    p;

    assign alt_out_all = {alt_out_d, alt_out_c, alt_out_b, alt_out_a};
    assign alt_oe_all  = {alt_oe_d, alt_oe_c, alt_oe_b, alt_oe_a};

    // Reset release through two flops
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    assign reg_hit  = (reg_addr >= `GPC_PORT_BASE) &&
                      (reg_addr < (`GPC_PORT_BASE + `GPC_PORT_SPAN));
    assign port_sel = reg_addr[3:2];
    assign reg_sel  = reg_addr[1:0];

    // Per-port register state
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (p = 0; p < `GPC_NPORTS; p = p + 1) begin
                sub_index[p] <= `GPC_SUB_NONE;
                dir_reg[p]   <= `GPC_RST_DIR;
                alt_en[p]    <= `GPC_RST_ALT_ABC;
                od_reg[p]    <= `GPC_RST_ZERO;
                hd_reg[p]    <= `GPC_RST_ZERO;
                wake_reg[p]  <= `GPC_RST_ZERO;
                pu_reg[p]    <= `GPC_RST_ZERO;
                sel1_reg[p]  <= `GPC_RST_ZERO;
                sel2_reg[p]  <= `GPC_RST_ZERO;
                out_reg[p]   <= `GPC_RST_ZERO;
                in_reg[p]    <= `GPC_RST_ZERO;
            end
            alt_en[`GPC_PORT_D] <= `GPC_RST_ALT_D;
            if (EIGHT_PIN != 0) begin
                alt_en[0]   <= `GPC_RST_ALT_A8;
                sel1_reg[0] <= `GPC_RST_SEL_A8;
                sel2_reg[0] <= `GPC_RST_SEL_A8;
            end
        end else begin
            for (p = 0; p < `GPC_NPORTS; p = p + 1) begin
                in_reg[p] <= pin_in[p*8 +: 8];
            end
            if (reg_wr && reg_hit) begin
                case (reg_sel)
                    `GPC_SEL_INDEX: sub_index[port_sel] <= reg_wdata;
                    `GPC_SEL_WINDOW: begin
                        case (sub_index[port_sel])
                            `GPC_SUB_DIR:        dir_reg[port_sel]  <= reg_wdata;
                            `GPC_SUB_ALT_EN:     alt_en[port_sel]   <= reg_wdata;
                            `GPC_SUB_OPEN_DRAIN: od_reg[port_sel]   <= reg_wdata;
                            `GPC_SUB_HIGH_DRIVE: hd_reg[port_sel]   <= reg_wdata;
                            `GPC_SUB_WAKE_SRC:   wake_reg[port_sel] <= reg_wdata;
                            `GPC_SUB_PULLUP:     pu_reg[port_sel]   <= reg_wdata;
                            `GPC_SUB_ALT_SEL1:   sel1_reg[port_sel] <= reg_wdata;
                            `GPC_SUB_ALT_SEL2:   sel2_reg[port_sel] <= reg_wdata;
                            default: ;
                        endcase
                    end
                    `GPC_SEL_OUT_DATA: out_reg[port_sel] <= reg_wdata;
                    default: ;
                endcase
            end
        end
    end

    // Window read mux; unused indices read zero
    wire [7:0] idx = sub_index[port_sel];
    assign win_rdata =
        (idx == `GPC_SUB_DIR)        ? dir_reg[port_sel]  :
        (idx == `GPC_SUB_ALT_EN)     ? alt_en[port_sel]   :
        (idx == `GPC_SUB_OPEN_DRAIN) ? od_reg[port_sel]   :
        (idx == `GPC_SUB_HIGH_DRIVE) ? hd_reg[port_sel]   :
        (idx == `GPC_SUB_WAKE_SRC)   ? wake_reg[port_sel] :
        (idx == `GPC_SUB_PULLUP)     ? pu_reg[port_sel]   :
        (idx == `GPC_SUB_ALT_SEL1)   ? sel1_reg[port_sel] :
        (idx == `GPC_SUB_ALT_SEL2)   ? sel2_reg[port_sel] : `GPC_RST_ZERO;

    always @* begin
        next_rdata = `GPC_RST_ZERO;
        if (reg_rd && reg_hit) begin
            case (reg_sel)
                `GPC_SEL_INDEX:    next_rdata = sub_index[port_sel];
                `GPC_SEL_WINDOW:   next_rdata = win_rdata;
                `GPC_SEL_IN_DATA:  next_rdata = in_reg[port_sel];
                `GPC_SEL_OUT_DATA: next_rdata = out_reg[port_sel];
                default: next_rdata = `GPC_RST_ZERO;
            endcase
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `GPC_RST_ZERO;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // Pin cells and wake detectors
    genvar gp;
    genvar gb;
    generate
        for (gp = 0; gp < 4; gp = gp + 1) begin : g_port
            for (gb = 0; gb < 8; gb = gb + 1) begin : g_pin
                wire [1:0] fsel;
                wire [3:0] fo;
                wire [3:0] fe;
                assign fsel = {sel2_reg[gp][gb], sel1_reg[gp][gb]};
                assign fo = alt_out_all[(gp*8+gb)*4 +: 4];
                assign fe = alt_oe_all[(gp*8+gb)*4 +: 4];
                assign pin_alt_sel[gp*8+gb] = alt_en[gp][gb];
                assign pin_alt_in[gp*8+gb]  = pin_in[gp*8+gb] & alt_en[gp][gb];
                gpc_pin_cell u_cell (
                    .direction_bit  (dir_reg[gp][gb]),
                    .alt_enable_bit (alt_en[gp][gb]),
                    .open_drain_bit (od_reg[gp][gb]),
                    .high_drive_bit (hd_reg[gp][gb]),
                    .pullup_bit     (pu_reg[gp][gb]),
                    .out_data       (out_reg[gp][gb]),
                    .alt_out        (fo[fsel]),
                    .alt_oe         (fe[fsel]),
                    .pin_out        (pin_out[gp*8+gb]),
                    .pin_oe         (pin_oe[gp*8+gb]),
                    .pin_high_drive (pin_high_drive[gp*8+gb]),
                    .pin_pullup     (pin_pullup[gp*8+gb])
                );
            end
            gpc_wake_det u_wake (
                .mclk        (mclk),
                .rst_n       (rst_n),
                .deep_sleep  (deep_sleep),
                .wake_enable (wake_reg[gp]),
                .pin_level   (pin_in[gp*8 +: 8]),
                .wake_req    (port_wake[gp])
            );
        end
    endgenerate

    assign wake_req = |port_wake;
endmodule

`default_nettype wire

// file: gpc_port_cfg_sva.sv
`timescale 1ns/100ps
`default_nettype none

module gpc_port_cfg_sva (
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic [11:0] reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_hit,
    input wire logic        deep_sleep,
    input wire logic        wake_req,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] pin_high_drive,
    input wire logic [31:0] pin_pullup,
    input wire logic [31:0] pin_alt_in,
    input wire logic [31:0] pin_alt_sel
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence set_index(logic [7:0] idx);
        reg_wr && reg_hit && reg_addr == 12'hFD0 && reg_wdata == idx;
    endsequence

    sequence win_write;
        reg_wr && reg_hit && reg_addr == 12'hFD1;
    endsequence

    property maps_to(logic [7:0] idx, logic [7:0] field);
        set_index(idx) ##1 win_write |=> field == $past(reg_wdata);
    endproperty

    alt_enable_map_a: assert property (maps_to(8'h02, pin_alt_sel[7:0]))
        else $error("alt enable not at pins");
    high_drive_map_a: assert property (maps_to(8'h04, pin_high_drive[7:0]))
        else $error("high drive not at pins");
    pullup_map_a: assert property (maps_to(8'h06, pin_pullup[7:0]))
        else $error("pullup not at pins");
    open_drain_a: assert property (set_index(8'h03) ##1 win_write ##0 reg_wdata == 8'hFF
        |=> (pin_oe[7:0] & pin_out[7:0]) == 8'h00)
        else $error("high side driven in open drain");
    idle_data_a: assert property (!(reg_rd && reg_hit) |=> reg_rdata == 8'h00)
        else $error("read data without read");
    null_index_a: assert property (set_index(8'h00) ##1 (reg_rd && reg_addr == 12'hFD1)
        |=> reg_rdata == 8'h00)
        else $error("index zero window not empty");
    hit_decode_a: assert property (reg_hit == (reg_addr[11:4] == 8'hFD))
        else $error("register hit decode wrong");
    sleep_only_a: assert property (wake_req |-> deep_sleep)
        else $error("wake request while awake");
    alt_gate_a: assert property ((pin_alt_in & ~pin_alt_sel) == 32'h0)
        else $error("alt input leaks on plain pin");
endmodule

bind gpc_port_cfg gpc_port_cfg_sva i_gpc_port_cfg_sva (
    .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .deep_sleep(deep_sleep), .wake_req(wake_req), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_high_drive(pin_high_drive), .pin_pullup(pin_pullup),
    .pin_alt_in(pin_alt_in), .pin_alt_sel(pin_alt_sel));

`default_nettype wire

// file: gpc_wake_det.v
`timescale 1ns/100ps
`default_nettype none
`include "gpc_consts.vh"

// Edge detector for wake sources
module gpc_wake_det (
    // Clock and reset
    input  wire       mclk,
    input  wire       rst_n,
    // Control
    input  wire       deep_sleep,
    input  wire [7:0] wake_enable,
    input  wire [7:0] pin_level,
    // Result
    output wire       wake_req
);
    reg [7:0] last_level;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            last_level <= `GPC_RST_ZERO;
        end else begin
            last_level <= pin_level;
        end
    end

    // Either edge counts; disabled pins are masked out
    assign wake_req = deep_sleep & |((last_level ^ pin_level) & wake_enable);
endmodule

`default_nettype wire

// file: test_gpc_port_cfg.sv
`timescale 1ns/100ps
`default_nettype none

module test_gpc_port_cfg;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        deep_sleep = 1'b0;
    logic [31:0] alt_out_a = 32'h0;
    logic [31:0] alt_oe_a = 32'h0;
    logic [31:0] ext_val = 32'h0;
    logic [31:0] ext_oe = 32'h0;
    logic [7:0]  reg_rdata;
    logic        reg_hit;
    logic        wake_req;
    logic [31:0] pin_in, pin_out, pin_oe, pin_high_drive, pin_pullup, pin_alt_in, pin_alt_sel;
    int          err_total = 0;
    int          samples_checked = 0;

    // Ports B..D share port A's alternate sources to keep every input live
    gpc_port_cfg #(.EIGHT_PIN(0)) i_gpc_port_cfg (
        .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .deep_sleep(deep_sleep), .wake_req(wake_req),
        .alt_out_a(alt_out_a), .alt_oe_a(alt_oe_a), .alt_out_b(alt_out_a), .alt_oe_b(alt_oe_a),
        .alt_out_c(alt_out_a), .alt_oe_c(alt_oe_a), .alt_out_d(alt_out_a), .alt_oe_d(alt_oe_a),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_high_drive(pin_high_drive),
        .pin_pullup(pin_pullup), .pin_alt_in(pin_alt_in), .pin_alt_sel(pin_alt_sel));

    gpc_pin_model i_gpc_pin_model (
        .mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .ext_val(ext_val), .ext_oe(ext_oe), .pin_in(pin_in));

    initial begin
        forever #2 mclk = ~mclk;
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Strobes are held to the next call, so calls may run back to back
    task automatic acc(input logic w, input logic r, input logic [11:0] a, input logic [7:0] d);
        reg_wr = w;
        reg_rd = r;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
    endtask

    task automatic sub_wr(input int p, input logic [7:0] idx, input logic [7:0] d);
        acc(1'b1, 1'b0, 12'hFD0 + 12'(4 * p), idx);
        acc(1'b1, 1'b0, 12'hFD1 + 12'(4 * p), d);
    endtask

    task automatic sub_rd(input int p, input logic [7:0] idx, input logic [7:0] exp);
        acc(1'b1, 1'b0, 12'hFD0 + 12'(4 * p), idx);
        acc(1'b0, 1'b1, 12'hFD1 + 12'(4 * p), 8'h00);
        check(32'(reg_rdata), 32'(exp));
    endtask

    task automatic wake_test(input logic [31:0] m, input logic exp);
        logic seen;
        seen = 1'b0;
        ext_val = ext_val ^ m;
        // Pulse only stands until the next rising edge
        repeat (6) begin
            #1 seen = seen | wake_req;
            @(negedge mclk);
        end
        check(32'(seen), 32'(exp));
    endtask

    function automatic logic [7:0] val(input int p, input int i);
        return (i == 2) ? 8'h04 : 8'((p + 1) * 8'h11 + i);
    endfunction

    initial begin
        repeat (5) @(negedge mclk);
        rstn = 1'b1;
        repeat (3) @(negedge mclk);
        for (int p = 0; p < 4; p++)
            for (int i = 2; i < 7; i++)
                sub_rd(p, 8'(i), (p == 3 && i == 2) ? 8'h01 : 8'h00);
        for (int p = 0; p < 4; p++)
            for (int i = 2; i < 7; i++)
                sub_wr(p, 8'(i), val(p, i));
        acc(1'b1, 1'b0, 12'hFE1, 8'h77);
        for (int p = 0; p < 4; p++)
            for (int i = 2; i < 7; i++)
                sub_rd(p, 8'(i), val(p, i));
        sub_wr(0, 8'h09, 8'h5A);
        sub_rd(0, 8'h09, 8'h00);
        sub_rd(0, 8'h00, 8'h00);
        sub_wr(0, 8'h01, 8'h00);
        acc(1'b1, 1'b0, 12'hFD3, 8'hFF);
        sub_wr(0, 8'h02, 8'h00);
        sub_wr(0, 8'h03, 8'hFF);
        sub_wr(0, 8'h03, 8'h0F);
        sub_wr(0, 8'h04, 8'h3C);
        sub_wr(0, 8'h06, 8'hA5);
        check(32'({pin_oe[7:0], pin_out[7:0]}), 32'hF0FF);
        check(32'(pin_high_drive[7:0]), 32'h3C);
        check(32'(pin_pullup[7:0]), 32'hA5);
        acc(1'b1, 1'b0, 12'hFD3, 8'h00);
        check(32'(pin_oe[7:0]), 32'hFF);
        sub_wr(0, 8'h02, 8'h04);
        check(32'(pin_alt_sel[7:0]), 32'h04);
        alt_oe_a = 32'hF00;
        for (int f = 0; f < 4; f++) begin
            sub_wr(0, 8'h07, f[0] ? 8'h04 : 8'h00);
            sub_wr(0, 8'h08, f[1] ? 8'h04 : 8'h00);
            alt_out_a = 32'h100 << f;
            @(negedge mclk);
            check(32'({pin_oe[2], pin_out[2]}), 32'h1);
            alt_out_a = ~(32'h100 << f);
            @(negedge mclk);
            check(32'({pin_oe[2], pin_out[2]}), 32'h2);
        end
        sub_wr(0, 8'h01, 8'hFF);
        check(32'(pin_oe[7:0]), 32'h04);
        ext_oe = 32'hFFFF_FFFF;
        sub_wr(0, 8'h05, 8'h01);
        acc(1'b0, 1'b0, 12'h000, 8'h00);
        deep_sleep = 1'b1;
        repeat (2) @(negedge mclk);
        wake_test(32'h2, 1'b0);
        wake_test(32'h1, 1'b1);
        wake_test(32'h1, 1'b1);
        deep_sleep = 1'b0;
        wake_test(32'h1, 1'b0);
        tally_and_finish();
    end

    // Whole sequence needs well under 1000 cycles
    initial begin
        #20000;
        err_total++;
        $display("ERROR %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule

`default_nettype wire
